// >>> rtl/asp_top.sv
`default_nettype none
module asp_top (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        hw_reset_n,
    // serial port pins
    input  wire logic        sclk,
    input  wire logic        mosi,
    input  wire logic        ss_n,
    output logic             miso_out,
    output logic             miso_oe_n,
    // converter and input selector
    output logic [2:0]       mux_sel,
    output logic             conv_start,
    input  wire logic        conv_done,
    input  wire logic [11:0] conv_code
);
    // pin synchronisers
    logic        rstn_meta_ff;
    logic        rstn_sync_ff;
    logic [2:0]  pin_meta_ff;
    logic [2:0]  pin_sync_ff;
    logic        sclk_prev_ff;
    logic        int_rst;
    logic        sclk_s;
    logic        mosi_s;
    logic        ss_act;
    logic        sclk_rise;
    logic        sclk_fall;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rstn_meta_ff <= 1'b1;
            rstn_sync_ff <= 1'b1;
            pin_meta_ff  <= 3'h4;
            pin_sync_ff  <= 3'h4;
        end else begin
            rstn_meta_ff <= hw_reset_n;
            rstn_sync_ff <= rstn_meta_ff;
            pin_meta_ff  <= {ss_n, sclk, mosi};
            pin_sync_ff  <= pin_meta_ff;
        end
    end

    assign int_rst   = rst | ~rstn_sync_ff;
    assign ss_act    = ~pin_sync_ff[2];
    assign sclk_s    = pin_sync_ff[1];
    assign mosi_s    = pin_sync_ff[0];
    assign sclk_rise = ss_act & sclk_s & ~sclk_prev_ff;
    assign sclk_fall = ss_act & ~sclk_s & sclk_prev_ff;

    always_ff @(posedge core_clk) begin
        if (int_rst) begin
            sclk_prev_ff <= 1'b0;
        end else begin
            sclk_prev_ff <= sclk_s;
        end
    end

    // scan sequencer
    asp_pkg::asp_seq_e   seq_ff;
    logic [2:0]          mux_sel_ff;
    logic                conv_start_ff;
    asp_pkg::asp_result_s cap_ff;
    logic                fifo_in_ready;
    logic                fifo_out_valid;
    logic                fifo_out_ready;
    asp_pkg::asp_result_s fifo_out_data;

    always_ff @(posedge core_clk) begin
        if (int_rst) begin
            seq_ff        <= asp_pkg::SEQ_START;
            mux_sel_ff    <= asp_pkg::CH_FIRST;
            conv_start_ff <= 1'b0;
            cap_ff        <= '0;
        end else begin
            conv_start_ff <= 1'b0;
            unique case (seq_ff)
                asp_pkg::SEQ_START: begin
                    conv_start_ff <= 1'b1;
                    seq_ff        <= asp_pkg::SEQ_WAIT;
                end
                asp_pkg::SEQ_WAIT: begin
                    if (conv_done) begin
                        cap_ff.chan <= mux_sel_ff;
                        cap_ff.code <= conv_code;
                        seq_ff      <= asp_pkg::SEQ_PUSH;
                    end
                end
                asp_pkg::SEQ_PUSH: begin
                    if (fifo_in_ready) begin
                        mux_sel_ff <= (mux_sel_ff == asp_pkg::CH_LAST) ? asp_pkg::CH_FIRST
                                                                      : 3'(mux_sel_ff + 1'b1);
                        seq_ff     <= asp_pkg::SEQ_START;
                    end
                end
                default: begin
                    seq_ff <= asp_pkg::SEQ_START;
                end
            endcase
        end
    end

    asp_fifo #(
        .WIDTH ($bits(asp_pkg::asp_result_s)),
        .DEPTH (asp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst       (int_rst),
        .in_valid  (seq_ff == asp_pkg::SEQ_PUSH),
        .in_ready  (fifo_in_ready),
        .in_data   (cap_ff),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // register file
    logic [11:0] result_ff [asp_pkg::NUM_CH];
    logic [15:0] ctrl_ff;
    logic [4:0]  bit_cnt_ff;
    logic [15:0] shift_in_ff;
    logic [15:0] cmd_ff;
    logic [15:0] shift_out_ff;
    logic        miso_ff;
    logic        miso_oe_n_ff;
    logic [15:0] cmd_word;
    logic        cmd_end;
    logic        data_end;

    function automatic logic [15:0] rd_word(input logic [3:0] addr);
        if (addr[3] == 1'b0) begin
            rd_word = {4'h0, result_ff[addr[2:0]]};
        end else if (addr == asp_pkg::CTRL_ADDR) begin
            rd_word = ctrl_ff;
        end else begin
            rd_word = 16'h0000;
        end
    endfunction

    assign cmd_word  = {shift_in_ff[14:0], mosi_s};
    assign cmd_end   = sclk_rise & (bit_cnt_ff == asp_pkg::CMD_LAST_BIT);
    assign data_end  = sclk_rise & (bit_cnt_ff == asp_pkg::DATA_LAST_BIT);
    // hold drain for the snapshot cycle so a read sees one stable word
    assign fifo_out_ready = ~cmd_end;

    always_ff @(posedge core_clk) begin
        if (int_rst) begin
            for (int i = 0; i < asp_pkg::NUM_CH; i++) begin
                result_ff[i] <= asp_pkg::CODE_RST;
            end
        end else if (fifo_out_valid & fifo_out_ready) begin
            result_ff[fifo_out_data.chan] <= fifo_out_data.code;
        end
    end

    always_ff @(posedge core_clk) begin
        if (int_rst) begin
            ctrl_ff <= asp_pkg::CTRL_RST;
        end else if (data_end & ~cmd_ff[asp_pkg::CMD_READ_POS] & (cmd_ff[3:0] == asp_pkg::CTRL_ADDR)) begin
            ctrl_ff <= cmd_word;
        end
    end

    // serial shifter, mode 0: sample on rising, shift out on falling
    always_ff @(posedge core_clk) begin
        if (int_rst | ~ss_act) begin
            bit_cnt_ff  <= 5'h00;
            shift_in_ff <= 16'h0000;
            cmd_ff      <= 16'h0000;
        end else if (sclk_rise) begin
            shift_in_ff <= cmd_word;
            bit_cnt_ff  <= 5'(bit_cnt_ff + 1'b1);
            if (cmd_end) begin
                cmd_ff <= cmd_word;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (int_rst | ~ss_act) begin
            shift_out_ff <= 16'h0000;
            miso_ff      <= 1'b0;
        end else if (cmd_end) begin
            shift_out_ff <= cmd_word[asp_pkg::CMD_READ_POS] ? rd_word(cmd_word[3:0]) : 16'h0000;
        end else if (sclk_fall) begin
            miso_ff      <= shift_out_ff[15];
            shift_out_ff <= {shift_out_ff[14:0], 1'b0};
        end
    end

    always_ff @(posedge core_clk) begin
        if (int_rst) begin
            miso_oe_n_ff <= 1'b1;
        end else begin
            miso_oe_n_ff <= ~ss_act;
        end
    end

    assign miso_out   = miso_ff;
    assign miso_oe_n  = miso_oe_n_ff;
    assign mux_sel    = mux_sel_ff;
    assign conv_start = conv_start_ff;
endmodule
`default_nettype wire

// >>> rtl/asp_pkg.sv
`default_nettype none
package asp_pkg;
    localparam int          NUM_CH       = 8;
    localparam int          CH_W         = 3;
    localparam int          CODE_W       = 12;
    localparam int          REG_W        = 16;
    localparam int          ADDR_W       = 4;
    localparam int          FIFO_DEPTH   = 8;
    localparam int          CMD_READ_POS = 15;
    localparam logic [4:0]  CMD_LAST_BIT = 5'h0F;
    localparam logic [4:0]  DATA_LAST_BIT = 5'h1F;
    localparam logic [3:0]  CTRL_ADDR    = 4'h8;
    localparam logic [15:0] CTRL_RST     = 16'h0000;
    localparam logic [11:0] CODE_RST     = 12'h000;
    localparam logic [11:0] CODE_FULL    = 12'hFFF;
    localparam logic [2:0]  CH_FIRST     = 3'h0;
    localparam logic [2:0]  CH_LAST      = 3'h7;

    typedef struct packed {
        logic [CH_W-1:0]   chan;
        logic [CODE_W-1:0] code;
    } asp_result_s;

    typedef enum logic [2:0] {
        SEQ_START = 3'b001,
        SEQ_WAIT  = 3'b010,
        SEQ_PUSH  = 3'b100
    } asp_seq_e;
endpackage
`default_nettype wire

// >>> rtl/asp_fifo.sv
`default_nettype none
module asp_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      cnt_ff;
    logic             out_valid_ff;
    logic [WIDTH-1:0] out_data_ff;
    logic             push;
    logic             pop;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
    assign push      = in_valid & in_ready;
    assign pop       = (cnt_ff != '0) & (~out_valid_ff | out_ready);
    assign out_valid = out_valid_ff;
    assign out_data  = out_data_ff;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff    <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= ptr_inc(wr_ptr_ff);
            end
            if (pop) begin
                rd_ptr_ff <= ptr_inc(rd_ptr_ff);
            end
            if (push & ~pop) begin
                cnt_ff <= (AW+1)'(cnt_ff + 1'b1);
            end else if (pop & ~push) begin
                cnt_ff <= (AW+1)'(cnt_ff - 1'b1);
            end
        end
    end

    // output stage keeps read data in a register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            out_valid_ff <= 1'b0;
            out_data_ff  <= '0;
        end else if (pop) begin
            out_valid_ff <= 1'b1;
            out_data_ff  <= mem_ff[rd_ptr_ff];
        end else if (out_ready) begin
            out_valid_ff <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/asp_assertions.sv
`default_nettype none
module asp_assertions (
    // clock and resets
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        hw_reset_n,
    // serial port pins
    input wire logic        sclk,
    input wire logic        mosi,
    input wire logic        ss_n,
    input wire logic        miso_out,
    input wire logic        miso_oe_n,
    // converter side
    input wire logic [2:0]  mux_sel,
    input wire logic        conv_start,
    input wire logic        conv_done,
    input wire logic [11:0] conv_code
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst || !hw_reset_n);

    seq_step_a: assert property ($changed(mux_sel) |-> mux_sel == $past(mux_sel) + 3'h1)
        else $error("channel did not step by one");
    step_start_a: assert property ($changed(mux_sel) |=> conv_start)
        else $error("no start after channel step");
    sel_hold_a: assert property (conv_start |=> $stable(mux_sel) [*2])
        else $error("channel moved during conversion");
    scan_live_a: assert property (conv_start |-> ##[2:100] conv_start)
        else $error("scan stalled");
    start_pulse_a: assert property (conv_start |=> !conv_start)
        else $error("start longer than one cycle");
    first_chan_a: assert property ($fell(rst) |-> ##[0:2] (conv_start && mux_sel == 3'h0))
        else $error("scan did not restart at channel zero");
    miso_release_a: assert property (ss_n [*5] |-> miso_oe_n)
        else $error("data output driven while unselected");
    hw_reset_a: assert property (disable iff (rst)
        !hw_reset_n [*6] |-> (mux_sel == 3'h0 && !conv_start && miso_oe_n))
        else $error("reset pin did not reset logic");
endmodule
bind asp_top asp_assertions asp_assertions_inst (.core_clk(core_clk), .rst(rst), .hw_reset_n(hw_reset_n),
    .sclk(sclk), .mosi(mosi), .ss_n(ss_n), .miso_out(miso_out), .miso_oe_n(miso_oe_n),
    .mux_sel(mux_sel), .conv_start(conv_start), .conv_done(conv_done), .conv_code(conv_code));
`default_nettype wire

// >>> testbench/asp_host_model.sv
`default_nettype none
module asp_host_model (
    // clock
    input  wire logic core_clk,
    // serial port, host side
    input  wire logic miso,
    output var logic  sclk,
    output var logic  mosi,
    output var logic  ss_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sclk = 1'b0;
        mosi = 1'b0;
        ss_n = 1'b1;
    end
    // one 32-bit mode 0 frame; sel low keeps the device unselected
    task automatic xfer(input logic sel, input logic [15:0] cmd, input logic [15:0] wdat, output logic [15:0] rdat);
        logic [31:0] sh;
        sh = {cmd, wdat};
        rdat = 16'h0000;
        @(posedge core_clk);
        ss_n <= ~sel;
        repeat (4) @(posedge core_clk);
        for (int i = 0; i < 32; i++) begin
            mosi <= sh[31-i];
            repeat (4) @(posedge core_clk);
            sclk <= 1'b1;
            repeat (3) @(posedge core_clk);
            @(negedge core_clk);
            rdat = {rdat[14:0], miso};
            @(posedge core_clk);
            sclk <= 1'b0;
        end
        repeat (4) @(posedge core_clk);
        ss_n <= 1'b1;
        mosi <= ~mosi;
        repeat (8) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// >>> testbench/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk, rst, hw_reset_n, sclk, mosi, ss_n, miso_out, miso_oe_n;
    logic        conv_start, conv_done, flip;
    logic [2:0]  mux_sel, ch_q;
    logic [11:0] conv_code;
    logic [15:0] rd;
    wire logic   miso_w;
    int          n_errors, cmp_count, cyc, cnt;

    asp_top asp_top_inst (.core_clk(core_clk), .rst(rst), .hw_reset_n(hw_reset_n), .sclk(sclk), .mosi(mosi),
        .ss_n(ss_n), .miso_out(miso_out), .miso_oe_n(miso_oe_n), .mux_sel(mux_sel), .conv_start(conv_start),
        .conv_done(conv_done), .conv_code(conv_code));
    asp_host_model asp_host_model_inst (.core_clk(core_clk), .miso(miso_w), .sclk(sclk), .mosi(mosi), .ss_n(ss_n));
    assign miso_w = miso_oe_n ? 1'bz : miso_out;

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    function automatic logic [15:0] exp_code(input logic [2:0] ch, input logic f);
        return {4'h0, {3{1'b0, ch}} ^ {12{f}}};
    endfunction

    // converter: answers 4 to 11 cycles after start, scrambles code between answers
    // a reset aborts the conversion in flight so no stale answer meets the restarted scan
    always @(posedge core_clk) begin
        if (rst || !hw_reset_n) begin
            cnt       <= 0;
            conv_done <= 1'b0;
            conv_code <= 12'h000;
        end else if (conv_start) begin
            cnt       <= 4 + int'(mux_sel);
            ch_q      <= mux_sel;
            conv_done <= 1'b0;
            conv_code <= ~conv_code;
        end else begin
            cnt       <= (cnt > 0) ? cnt - 1 : 0;
            conv_done <= (cnt == 1);
            conv_code <= (cnt == 1) ? 12'(exp_code(ch_q, flip)) : ~conv_code;
        end
    end

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
        asp_host_model_inst.xfer(1'b1, {12'h800, a}, 16'h0000, rd);
        check(rd, exp, "register read");
    endtask

    task automatic t_scan;
        repeat (300) @(posedge core_clk);
        for (int c = 0; c < 8; c++) rd_reg(c[3:0], exp_code(c[2:0], flip));
    endtask

    task automatic t_replace;
        flip <= 1'b1;
        t_scan();
    endtask

    task automatic t_regs;
        asp_host_model_inst.xfer(1'b1, 16'h0008, 16'hA5C3, rd);
        rd_reg(4'h8, 16'hA5C3);
        rd_reg(4'hF, 16'h0000);
    endtask

    task automatic t_unselected;
        asp_host_model_inst.xfer(1'b0, 16'h0008, 16'h0000, rd);
        check(rd, 16'hZZZZ, "released data");
        check({15'h0, miso_oe_n}, 16'h0001, "output enable");
        rd_reg(4'h8, 16'hA5C3);
    endtask

    task automatic t_hw_reset;
        hw_reset_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        hw_reset_n <= 1'b1;
        repeat (10) @(posedge core_clk);
        rd_reg(4'h8, 16'h0000);
    endtask

    task automatic wait_start;
        for (int w = 0; w < 40; w++) begin
            @(negedge core_clk);
            if (conv_start) break;
        end
    endtask

    // one whole scan through the result queue after the code pattern flips back
    task automatic t_fifo;
        flip <= 1'b0;
        wait_start();
        for (int k = 0; k < 8 && mux_sel != 3'h0; k++) wait_start();
        for (int k = 1; k < 9; k++) begin
            wait_start();
            check({13'h0, mux_sel}, 16'(k % 8), "scan channel");
            @(negedge core_clk);
            check({15'h0, conv_start}, 16'h0000, "start pulse");
        end
        rd_reg(4'h7, exp_code(3'h7, 1'b0));
        rd_reg(4'h0, exp_code(3'h0, 1'b0));
        rd_reg(4'h9, 16'h0000);
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        hw_reset_n = 1'b1;
        flip = 1'b0;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        t_scan();
        t_regs();
        t_unselected();
        t_replace();
        t_hw_reset();
        t_fifo();
        wrap_up();
    end
endmodule
`default_nettype wire
